/* File: logic/uca_pkg.sv */
package uca_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h98;
    localparam logic [7:0] ADDR_DATA = 8'h99;
    localparam logic [7:0] ADDR_PCF = 8'hD9;
    localparam logic [7:0] ADDR_IST = 8'hE0;
    localparam logic [7:0] ADDR_IMSK = 8'hE1;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_MODE = 7;
    localparam int CTRL_RSV = 6;
    localparam int CTRL_FILT = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_TXN = 3;
    localparam int CTRL_RXN = 2;
    localparam int CTRL_TXDONE = 1;
    localparam int CTRL_RXAV = 0;
    localparam logic CTRL_RSV_VAL = 1'b1;
    localparam logic [1:0] PCF_RESET = 2'h0;

    // ----------------------------------------
    // Interrupt status and mask fields
    // ----------------------------------------
    localparam int IRQ_W = 3;
    localparam int IRQ_TXDONE = 0;
    localparam int IRQ_RXAVAIL = 1;
    localparam int IRQ_RXOVF = 2;
    localparam logic [IRQ_W-1:0] IST_RESET = 3'h0;
    localparam logic [IRQ_W-1:0] IMSK_RESET = 3'h0;

    // ----------------------------------------
    // Receive source codes and timing
    // ----------------------------------------
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam int BIT_CLKS_DEF = 868;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } uca_bus_req_t;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP} uca_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} uca_rx_state_t;
endpackage

/* File: logic/uca_uart_ctrl.sv */
`timescale 1ns/100ps
// Operation
// - Frame mode bit selects 8-bit frame (0) or 9-bit frame (1).
// - Filter on: accept only when stop bit (8-bit) or ninth bit (9-bit) is one.
// - Transmit-done flag set at start of stop bit; software clears it.
// - Software setting transmit-done raises the port interrupt when enabled.
// - Receive-available set at stop sampling, stays while receive FIFO holds data.
// - Receive-available clears when receive FIFO empties; read-only.
// - Data port write with transmit FIFO not full queues the byte.
// - Transmission starts once the transmitter is idle and transmit FIFO holds a byte.
// - Data port write with transmit FIFO full overwrites newest entry.
// - Data port read returns and removes oldest receive byte.
// - Data port read with receive FIFO empty returns last available byte.
// - Receive source: 0 pin, 1..3 logic units 0..2.
module uca_uart_ctrl
    import uca_pkg::*;
#(
    parameter int BIT_CLKS = BIT_CLKS_DEF,
    parameter int TX_DEPTH = 4,
    parameter int RX_DEPTH = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire uca_bus_req_t busReq,
    output logic [7:0] rdData,
    // Serial lines
    output logic txd,
    input wire logic rxPin,
    input wire logic logicUnit0Out,
    input wire logic logicUnit1Out,
    input wire logic logicUnit2Out,
    // Interrupt
    output logic irq
);
    localparam int TAW = $clog2(TX_DEPTH);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int TMW = $clog2(BIT_CLKS + 1);
    localparam logic [TMW-1:0] TMR_FULL = TMW'(BIT_CLKS - 1);
    localparam logic [TMW-1:0] TMR_HALF = TMW'(BIT_CLKS / 2 - 1);
    localparam logic [TAW:0] TX_CAP = (TAW+1)'(TX_DEPTH);
    localparam logic [RAW:0] RX_CAP = (RAW+1)'(RX_DEPTH);

    // ----------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------
    logic [1:0] rstSync_r;
    logic rstN;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) rstSync_r <= 2'h0;
        else rstSync_r <= {rstSync_r[0], 1'b1};
    end
    assign rstN = rstSync_r[1];

    logic [3:0] rxRaw;
    logic [3:0] rxMeta_r;
    logic [3:0] rxSafe_r;
    assign rxRaw = {logicUnit2Out, logicUnit1Out, logicUnit0Out, rxPin};
    for (genvar i = 0; i < 4; i++) begin : g_sync
        always_ff @(posedge mclk or negedge rstN) begin
            if (!rstN) begin
                rxMeta_r[i] <= 1'b1;
                rxSafe_r[i] <= 1'b1;
            end else begin
                rxMeta_r[i] <= rxRaw[i];
                rxSafe_r[i] <= rxMeta_r[i];
            end
        end
    end

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    logic modeSel_r, filtEn_r, renEn_r, txNinth_r, rxNinth_r, txDone_r;
    logic [1:0] rxSrcSel_r;
    logic [IRQ_W-1:0] irqStat_r, irqMask_r;
    wire wrCtrl = busReq.wr && busReq.addr == ADDR_CTRL;
    wire wrData = busReq.wr && busReq.addr == ADDR_DATA;
    wire wrPcf = busReq.wr && busReq.addr == ADDR_PCF;
    wire wrIst = busReq.wr && busReq.addr == ADDR_IST;
    wire wrImsk = busReq.wr && busReq.addr == ADDR_IMSK;
    wire rdData_s = busReq.rd && busReq.addr == ADDR_DATA;
    wire rxSerial = rxSafe_r[rxSrcSel_r];

    // ----------------------------------------
    // Transmit FIFO
    // ----------------------------------------
    logic [7:0] txMem [TX_DEPTH];
    logic [TAW-1:0] txWp_r, txRp_r;
    logic [TAW:0] txCnt_r;
    logic txPop;
    wire txNotFull = txCnt_r != TX_CAP;
    wire txEmpty = txCnt_r == '0;
    wire [TAW-1:0] txLastWp = txWp_r - TAW'(1);
    wire txPush = wrData && txNotFull;
    always_ff @(posedge mclk) begin
        if (txPush) txMem[txWp_r] <= busReq.wdata;
        else if (wrData && !txEmpty) txMem[txLastWp] <= busReq.wdata;
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txWp_r <= '0;
            txRp_r <= '0;
            txCnt_r <= '0;
        end else begin
            if (txPush) txWp_r <= txWp_r + TAW'(1);
            if (txPop) txRp_r <= txRp_r + TAW'(1);
            txCnt_r <= txCnt_r + (TAW+1)'(txPush) - (TAW+1)'(txPop);
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    uca_tx_state_t txSt_r, txSt_nxt;
    logic [TMW-1:0] txTmr_r;
    logic [8:0] txSh_r;
    logic [2:0] txIdx_r;
    logic txBit;
    wire txTick = txTmr_r == TMR_FULL;
    assign txPop = txSt_r == TX_IDLE && !txEmpty;
    wire txDoneSet = txSt_r != TX_STOP && txSt_nxt == TX_STOP;
    always_comb begin
        txSt_nxt = txSt_r;
        unique case (txSt_r)
            TX_IDLE: if (!txEmpty) txSt_nxt = TX_START;
            TX_START: if (txTick) txSt_nxt = TX_DATA;
            TX_DATA: if (txTick && txIdx_r == 3'h7) txSt_nxt = modeSel_r ? TX_NINTH : TX_STOP;
            TX_NINTH: if (txTick) txSt_nxt = TX_STOP;
            TX_STOP: if (txTick) txSt_nxt = TX_IDLE;
        endcase
    end
    always_comb begin
        unique case (txSt_r)
            TX_START: txBit = 1'b0;
            TX_DATA: txBit = txSh_r[txIdx_r];
            TX_NINTH: txBit = txSh_r[8];
            default: txBit = 1'b1;
        endcase
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txSt_r <= TX_IDLE;
            txTmr_r <= '0;
            txSh_r <= '0;
            txIdx_r <= '0;
            txd <= 1'b1;
        end else begin
            txSt_r <= txSt_nxt;
            txd <= txBit;
            txTmr_r <= (txTick || txSt_r == TX_IDLE) ? '0 : txTmr_r + TMW'(1);
            if (txPop) txSh_r <= {txNinth_r, txMem[txRp_r]};
            if (txSt_r == TX_DATA && txTick) txIdx_r <= txIdx_r + 3'h1;
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    uca_rx_state_t rxSt_r;
    logic [TMW-1:0] rxTmr_r;
    logic [7:0] rxSh_r;
    logic rxBit9_r;
    logic [2:0] rxIdx_r;
    logic [RAW:0] rxCnt_r;
    wire rxTick = rxTmr_r == TMR_FULL;
    wire rxEmpty = rxCnt_r == '0;
    wire rxFull = rxCnt_r == RX_CAP;
    wire rxFrameBit = modeSel_r ? rxBit9_r : rxSerial;
    wire rxStopDone = rxSt_r == RX_STOP && rxTick;
    wire rxAccept = rxStopDone && renEn_r && (!filtEn_r || rxFrameBit);
    wire rxPush = rxAccept && !rxFull;
    wire rxOvf = rxAccept && rxFull;
    wire rxPop = rdData_s && !rxEmpty;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rxSt_r <= RX_IDLE;
            rxTmr_r <= '0;
            rxSh_r <= '0;
            rxBit9_r <= 1'b0;
            rxIdx_r <= '0;
        end else begin
            rxTmr_r <= (rxTick || rxSt_r == RX_IDLE) ? '0 : rxTmr_r + TMW'(1);
            unique case (rxSt_r)
                RX_IDLE: if (renEn_r && !rxSerial) rxSt_r <= RX_START;
                RX_START: begin
                    if (rxTmr_r == TMR_HALF) begin
                        rxTmr_r <= '0;
                        rxIdx_r <= '0;
                        rxSt_r <= rxSerial ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rxTick) begin
                        rxSh_r <= {rxSerial, rxSh_r[7:1]};
                        rxIdx_r <= rxIdx_r + 3'h1;
                        if (rxIdx_r == 3'h7) rxSt_r <= modeSel_r ? RX_NINTH : RX_STOP;
                    end
                end
                RX_NINTH: begin
                    if (rxTick) begin
                        rxBit9_r <= rxSerial;
                        rxSt_r <= RX_STOP;
                    end
                end
                RX_STOP: if (rxTick) rxSt_r <= RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receive FIFO
    // ----------------------------------------
    logic [7:0] rxMem [RX_DEPTH];
    logic [RAW-1:0] rxWp_r, rxRp_r;
    logic [7:0] rxLast_r;
    always_ff @(posedge mclk) begin
        if (rxPush) rxMem[rxWp_r] <= rxSh_r;
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rxWp_r <= '0;
            rxRp_r <= '0;
            rxCnt_r <= '0;
            rxLast_r <= 8'h00;
        end else begin
            if (rxPush) rxWp_r <= rxWp_r + RAW'(1);
            if (rxPop) rxRp_r <= rxRp_r + RAW'(1);
            if (rxPop) rxLast_r <= rxMem[rxRp_r];
            rxCnt_r <= rxCnt_r + (RAW+1)'(rxPush) - (RAW+1)'(rxPop);
        end
    end

    // ----------------------------------------
    // Control, status and interrupt registers
    // ----------------------------------------
    // Flag follows FIFO occupancy, so it cannot be cleared by software
    wire rxAvail = !rxEmpty;
    wire txDoneNxt = txDoneSet || (wrCtrl ? busReq.wdata[CTRL_TXDONE] : txDone_r);
    logic [IRQ_W-1:0] irqEvt;
    always_comb begin
        irqEvt = '0;
        irqEvt[IRQ_TXDONE] = txDoneNxt && !txDone_r;
        irqEvt[IRQ_RXAVAIL] = rxPush;
        irqEvt[IRQ_RXOVF] = rxOvf;
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            modeSel_r <= 1'b0;
            filtEn_r <= 1'b0;
            renEn_r <= 1'b0;
            txNinth_r <= 1'b0;
            rxNinth_r <= 1'b0;
            txDone_r <= 1'b0;
            rxSrcSel_r <= PCF_RESET;
            irqStat_r <= IST_RESET;
            irqMask_r <= IMSK_RESET;
        end else begin
            if (wrCtrl) begin
                modeSel_r <= busReq.wdata[CTRL_MODE];
                filtEn_r <= busReq.wdata[CTRL_FILT];
                renEn_r <= busReq.wdata[CTRL_REN];
                txNinth_r <= busReq.wdata[CTRL_TXN];
            end
            txDone_r <= txDoneNxt;
            if (rxPush) rxNinth_r <= rxFrameBit;
            if (wrPcf) rxSrcSel_r <= busReq.wdata[1:0];
            if (wrImsk) irqMask_r <= busReq.wdata[IRQ_W-1:0];
            // New events win over a write-one clear in the same cycle
            irqStat_r <= irqEvt | (irqStat_r & ~(wrIst ? busReq.wdata[IRQ_W-1:0] : '0));
        end
    end
    assign irq = |(irqStat_r & irqMask_r);

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    logic [7:0] ctrlView, rdMux;
    always_comb begin
        ctrlView = 8'h00;
        ctrlView[CTRL_MODE] = modeSel_r;
        ctrlView[CTRL_RSV] = CTRL_RSV_VAL;
        ctrlView[CTRL_FILT] = filtEn_r;
        ctrlView[CTRL_REN] = renEn_r;
        ctrlView[CTRL_TXN] = txNinth_r;
        ctrlView[CTRL_RXN] = rxNinth_r;
        ctrlView[CTRL_TXDONE] = txDone_r;
        ctrlView[CTRL_RXAV] = rxAvail;
        unique case (busReq.addr)
            ADDR_CTRL: rdMux = ctrlView;
            ADDR_DATA: rdMux = rxEmpty ? rxLast_r : rxMem[rxRp_r];
            ADDR_PCF: rdMux = {6'h00, rxSrcSel_r};
            ADDR_IST: rdMux = {{(8-IRQ_W){1'b0}}, irqStat_r};
            ADDR_IMSK: rdMux = {{(8-IRQ_W){1'b0}}, irqMask_r};
            default: rdMux = 8'h00;
        endcase
    end
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) rdData <= 8'h00;
        else if (busReq.rd) rdData <= rdMux;
        else rdData <= 8'h00;
    end
endmodule

/* File: verif/uca_peer.sv */
`timescale 1ns/100ps
module uca_peer #(
    parameter int B = 8
) (
    // Clock
    input wire logic mclk,
    // Device transmit side
    input wire logic txd,
    input wire logic nine,
    // Towards device and bench
    output logic ser,
    output logic gotByte,
    output logic [9:0] gotData
);
    logic [9:0] v;
    initial begin
        ser = 1'b1;
        gotByte = 1'b0;
        gotData = 10'h000;
    end
    // Start, data LSB first, ninth only in 9-bit mode, stop
    task automatic sendFrame(input logic [7:0] d, input logic n, input logic m, input logic stop);
        logic [10:0] f;
        f = {stop, n, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            if (i != 9 || m) begin
                @(posedge mclk);
                ser <= f[i];
                repeat (B - 1) @(posedge mclk);
            end
        end
        @(posedge mclk);
        ser <= 1'b1;
    endtask
    // Mid-bit sampling; bit 8 is ninth or stop
    always begin
        @(negedge txd);
        repeat (B / 2) @(posedge mclk);
        for (int i = 0; i < 10; i++) begin
            if (i < 9 || nine) begin
                repeat (B) @(posedge mclk);
                v[i] = txd;
            end else begin
                v[i] = 1'b1;
            end
        end
        gotData <= v;
        gotByte <= 1'b1;
        @(posedge mclk);
        gotByte <= 1'b0;
    end
endmodule

/* File: verif/uca_uart_ctrl_monitor.sv */
`timescale 1ns/100ps
module uca_uart_ctrl_monitor
    import uca_pkg::*;
#(
    parameter int BIT_CLKS = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Watched ports
    input wire uca_bus_req_t busReq,
    input wire logic [7:0] rdData,
    input wire logic txd,
    input wire logic irq
);
    // ----------------------------------------
    // Line run counters
    // ----------------------------------------
    int lowRun_r;
    int highRun_r;
    logic idle_w;
    logic mapped_w;
    // Ten quiet bits means transmitter idle and queue empty
    assign idle_w = highRun_r >= 10 * BIT_CLKS;
    assign mapped_w = busReq.addr inside {ADDR_CTRL, ADDR_DATA, ADDR_PCF, ADDR_IST, ADDR_IMSK};
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lowRun_r <= 0;
            highRun_r <= 0;
        end else begin
            lowRun_r <= txd ? 0 : lowRun_r + 1;
            highRun_r <= txd ? highRun_r + 1 : 0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence startBit;
        !txd [*7];
    endsequence
    sequence pcfWrRd;
        busReq.wr && busReq.addr == ADDR_PCF ##2 busReq.rd && busReq.addr == ADDR_PCF;
    endsequence
    AST_RD_QUIET: assert property (!busReq.rd |=> rdData == 8'h00)
        else $error("read data not idle");
    AST_UNMAPPED: assert property (busReq.rd && !mapped_w |=> rdData == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_RSV: assert property (busReq.rd && busReq.addr == ADDR_CTRL |=> rdData[CTRL_RSV])
        else $error("reserved control bit wrong");
    AST_PCF: assert property (pcfWrRd |=> rdData[1:0] == $past(busReq.wdata[1:0], 3))
        else $error("source select readback wrong");
    AST_IRQ_OFF: assert property (busReq.wr && busReq.addr == ADDR_IMSK && busReq.wdata[2:0] == 3'h0 |=> !irq)
        else $error("masked interrupt still high");
    AST_TX_START: assert property ($fell(txd) |-> ##1 startBit)
        else $error("start bit too short");
    AST_BIT_LEN: assert property ($rose(txd) |-> lowRun_r % BIT_CLKS == 0)
        else $error("low run not whole bits");
    AST_TX_KICK: assert property (busReq.wr && busReq.addr == ADDR_DATA && idle_w |-> ##[1:6] $fell(txd))
        else $error("transmission did not start");
endmodule

/* File: verif/uca_uart_ctrl_test.sv */
`timescale 1ns/100ps
module uca_uart_ctrl_test
    import uca_pkg::*;
();
    localparam int B = 8;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    uca_bus_req_t busReq = '0;
    logic [7:0] rdData;
    logic txd, irq, ser, gotByte, m, n;
    logic txNine = 1'b0;
    logic rdPend = 1'b0;
    logic [1:0] srcSel = 2'h0;
    logic [9:0] gotData;
    logic [15:0] rdNote;
    logic [15:0] rdQ[$];
    logic [9:0] txQ[$];
    logic [7:0] d, dv[5];
    logic [31:0] seed = 32'h0000CF08;
    int err_total = 0;
    int compares = 0;
    int k, s;
    always #5 mclk = ~mclk;
    // Unselected sources idle high, so a source switch never looks like a start bit
    uca_uart_ctrl #(.BIT_CLKS(B)) DUT (.mclk(mclk), .resetn(resetn), .busReq(busReq), .rdData(rdData),
        .txd(txd), .rxPin(srcSel == 2'h0 ? ser : 1'b1), .logicUnit0Out(srcSel == 2'h1 ? ser : 1'b1),
        .logicUnit1Out(srcSel == 2'h2 ? ser : 1'b1), .logicUnit2Out(srcSel == 2'h3 ? ser : 1'b1), .irq(irq));
    uca_peer #(.B(B)) peer (.mclk(mclk), .txd(txd), .nine(txNine), .ser(ser), .gotByte(gotByte), .gotData(gotData));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] rnd8();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task fail(input logic [15:0] e, input logic [15:0] g);
        err_total++;
        $display("mismatch at %0t exp=%h got=%h", $time, e, g);
    endtask
    task checkRd(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) fail(e, g);
    endtask
    task checkTx(input logic [9:0] e, input logic [9:0] g);
        compares++;
        if (g !== e) fail(e, g);
    endtask
    task checkIrq(input logic e);
        repeat (3) @(posedge mclk);
        compares++;
        if (irq !== e) fail(e, irq);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq <= '0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] msk);
        rdQ.push_back({msk, e});
        @(posedge mclk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq <= '0;
    endtask
    task waitTx();
        for (k = 0; k < 4000 && txQ.size() != 0; k++) @(posedge mclk);
        // A frame that never arrives counts as a mismatch
        if (txQ.size() != 0) fail(16'h0000, 16'(txQ.size()));
        repeat (100) @(posedge mclk);
    endtask
    task report_and_stop();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        rdPend <= busReq.rd;
        if (rdPend) begin
            rdNote = rdQ.pop_front();
            checkRd(rdNote[7:0] & rdNote[15:8], rdData & rdNote[15:8]);
        end
        if (gotByte) checkTx(txQ.pop_front(), gotData);
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(ADDR_CTRL, 8'h40, 8'hFB);
        rd(ADDR_PCF, 8'h00, 8'h03);
        rd(ADDR_DATA, 8'h00, 8'hFF);
        rd(8'h55, 8'h00, 8'hFF);
        d = rnd8();
        txQ.push_back({2'h3, d});
        wr(ADDR_DATA, d);
        for (k = 0; k < 200 && txd; k++) @(posedge mclk);
        // Shifter busy: four fit, the fifth replaces the newest
        for (s = 0; s < 5; s++) begin
            d = rnd8();
            if (s < 4) txQ.push_back({2'h3, d});
            else txQ[$] = {2'h3, d};
            wr(ADDR_DATA, d);
        end
        waitTx();
        rd(ADDR_CTRL, 8'h02, 8'h02);
        wr(ADDR_CTRL, 8'h40);
        rd(ADDR_CTRL, 8'h00, 8'h02);
        txNine = 1'b1;
        for (s = 0; s < 2; s++) begin
            wr(ADDR_CTRL, 8'hC0 | (s[7:0] << 3));
            d = rnd8();
            txQ.push_back({1'b1, s[0], d});
            wr(ADDR_DATA, d);
            waitTx();
        end
        txNine = 1'b0;
        wr(ADDR_CTRL, 8'h40);
        wr(ADDR_IST, 8'h07);
        wr(ADDR_IMSK, 8'h01);
        checkIrq(1'b0);
        wr(ADDR_CTRL, 8'h42);
        checkIrq(1'b1);
        wr(ADDR_IMSK, 8'h00);
        checkIrq(1'b0);
        wr(ADDR_IMSK, 8'h01);
        checkIrq(1'b1);
        wr(ADDR_IST, 8'h01);
        checkIrq(1'b0);
        for (s = 0; s < 4; s++) begin
            m = s[0];
            wr(ADDR_CTRL, 8'h40);
            wr(ADDR_PCF, s[7:0]);
            rd(ADDR_PCF, s[7:0], 8'h03);
            srcSel <= s[1:0];
            wr(ADDR_CTRL, {m, 3'h5, 4'h0});
            d = rnd8();
            n = d[3];
            peer.sendFrame(d, n, m, 1'b1);
            repeat (4) @(posedge mclk);
            rd(ADDR_CTRL, {5'h00, m ? n : 1'b1, 2'h1}, 8'h05);
            rd(ADDR_DATA, d, 8'hFF);
        end
        // Filter: 8-bit stop low, 9-bit ninth low, 9-bit ninth high
        for (s = 0; s < 3; s++) begin
            m = s != 0;
            wr(ADDR_CTRL, {m, 3'h7, 4'h0});
            d = rnd8();
            peer.sendFrame(d, s == 2, m, m);
            repeat (4) @(posedge mclk);
            rd(ADDR_CTRL, {7'h00, s == 2}, 8'h01);
        end
        rd(ADDR_DATA, d, 8'hFF);
        wr(ADDR_IST, 8'h07);
        wr(ADDR_IMSK, 8'h02);
        wr(ADDR_CTRL, 8'h50);
        for (s = 0; s < 3; s++) begin
            dv[s] = rnd8();
            if (s == 2) wr(ADDR_CTRL, 8'h40);
            peer.sendFrame(dv[s], 1'b1, 1'b0, 1'b1);
        end
        checkIrq(1'b1);
        rd(ADDR_DATA, dv[0], 8'hFF);
        rd(ADDR_DATA, dv[1], 8'hFF);
        rd(ADDR_CTRL, 8'h00, 8'h01);
        rd(ADDR_DATA, dv[1], 8'hFF);
        wr(ADDR_IST, 8'h02);
        checkIrq(1'b0);
        // Overflow: fifth byte is dropped, the oldest four are kept
        wr(ADDR_IMSK, 8'h04);
        wr(ADDR_CTRL, 8'h50);
        for (s = 0; s < 5; s++) begin
            dv[s] = rnd8();
            peer.sendFrame(dv[s], 1'b1, 1'b0, 1'b1);
        end
        checkIrq(1'b1);
        for (s = 0; s < 4; s++) begin
            rd(ADDR_DATA, dv[s], 8'hFF);
        end
        repeat (4) @(posedge mclk);
        report_and_stop();
    end
endmodule
bind uca_uart_ctrl uca_uart_ctrl_monitor #(.BIT_CLKS(BIT_CLKS)) mon (.mclk(mclk), .resetn(resetn), .busReq(busReq),
    .rdData(rdData), .txd(txd), .irq(irq));
